// ---- hdl/fx_pcs.sv ----
// 100 Mb/s coding path: nibbles to MLT-3 drive streams and back.
// Assumes MAC signals on clk; line clock and line inputs are asynchronous.
module fx_pcs
    import fx_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic line_clk,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    output logic tx_take_ff,
    output logic tx_p_ff,
    output logic tx_n_ff,
    input wire logic rx_p,
    input wire logic rx_n,
    output logic [3:0] rxd_ff,
    output logic rx_dv_ff,
    output logic rx_nib_vld_ff,
    output logic rx_er_ff,
    output logic rx_lock_ff
);
    // Synchronisers: first stages feed only the second stages
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic clk_prev_ff;
    logic tick;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            // Clock bit resets high so release never fakes a rise
            meta_ff <= 3'h4;
            sync_ff <= 3'h4;
            clk_prev_ff <= 1'b1;
        end else begin
            meta_ff <= {line_clk, rx_p, rx_n};
            sync_ff <= meta_ff;
            clk_prev_ff <= sync_ff[2];
        end
    end

    // Line clock rise marks one bit time in both directions
    assign tick = sync_ff[2] & ~clk_prev_ff;

    // Transmit coding
    fx_scr_if #(.W(GRP_W)) tx_sif ();
    fx_tx_e tx_st_ff;
    fx_tx_e nxt_tx_st;
    logic [GRP_W-1:0] nxt_grp;
    logic [GRP_W-1:0] sh_ff;
    logic [2:0] bit_cnt_ff;
    logic slot;
    logic nrzi_ff;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;

    assign slot = tick && (bit_cnt_ff == BIT_LAST);

    always_comb begin
        nxt_tx_st = TX_IDLE;
        unique case (tx_st_ff)
            TX_IDLE: nxt_tx_st = tx_en ? TX_J : TX_IDLE;
            TX_J: nxt_tx_st = TX_K;
            TX_K, TX_DATA: nxt_tx_st = tx_en ? TX_DATA : TX_T;
            TX_T: nxt_tx_st = TX_R;
            TX_R: nxt_tx_st = tx_en ? TX_J : TX_IDLE;
        endcase
    end

    always_comb begin
        nxt_grp = CG_I;
        unique case (nxt_tx_st)
            TX_IDLE: nxt_grp = CG_I;
            TX_J: nxt_grp = CG_J;
            TX_K: nxt_grp = CG_K;
            TX_DATA: nxt_grp = fx_enc(txd);
            TX_T: nxt_grp = CG_T;
            TX_R: nxt_grp = CG_R;
        endcase
    end

    assign tx_sif.step = slot;
    assign tx_sif.seed_en = 1'b0;
    assign tx_sif.seed = '0;

    fx_scr #(.W(GRP_W)) u_tx_scr (
        .clk(clk),
        .resetn(resetn),
        .sif(tx_sif)
    );

    // J and K each consume one preamble nibble, so the MAC paces evenly
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_st_ff <= TX_IDLE;
            tx_take_ff <= 1'b0;
        end else begin
            tx_take_ff <= slot && (nxt_tx_st inside {TX_J, TX_K, TX_DATA});
            if (slot) begin
                tx_st_ff <= nxt_tx_st;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sh_ff <= CG_I;
            bit_cnt_ff <= 3'h0;
        end else if (slot) begin
            sh_ff <= nxt_grp ^ tx_sif.key;
            bit_cnt_ff <= 3'h0;
        end else if (tick) begin
            sh_ff <= {sh_ff[GRP_W-2:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end

    assign nxt_phase = phase_ff + {1'b0, sh_ff[GRP_W-1]};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            nrzi_ff <= 1'b0;
            phase_ff <= 2'h0;
            tx_p_ff <= 1'b0;
            tx_n_ff <= 1'b0;
        end else if (tick) begin
            nrzi_ff <= nrzi_ff ^ sh_ff[GRP_W-1];
            phase_ff <= nxt_phase;
            tx_p_ff <= (nxt_phase == MLT_POS);
            tx_n_ff <= (nxt_phase == MLT_NEG);
        end
    end

    // Receive decoding
    fx_scr_if #(.W(1)) rx_sif ();
    logic [1:0] lvl_ff;
    logic rx_nrzi_ff;
    logic rx_nrzi_prev_ff;
    logic nrz;
    logic plain;
    logic [4:0] ones_ff;
    logic [9:0] win_ff;
    logic [2:0] rx_cnt_ff;
    logic pre2_ff;
    logic [GRP_W-1:0] grp;
    fx_dec_s dec;
    fx_rx_e rx_st_ff;

    // Level change on the line is an NRZI toggle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lvl_ff <= 2'h0;
            rx_nrzi_ff <= 1'b0;
            rx_nrzi_prev_ff <= 1'b0;
        end else if (tick) begin
            lvl_ff <= sync_ff[1:0];
            rx_nrzi_ff <= rx_nrzi_ff ^ (sync_ff[1:0] != lvl_ff);
            rx_nrzi_prev_ff <= rx_nrzi_ff;
        end
    end

    assign nrz = rx_nrzi_ff ^ rx_nrzi_prev_ff;
    assign rx_sif.step = tick;
    assign rx_sif.seed_en = ~rx_lock_ff;
    assign rx_sif.seed = ~nrz;
    assign plain = nrz ^ rx_sif.key[0];

    fx_scr #(.W(1)) u_rx_scr (
        .clk(clk),
        .resetn(resetn),
        .sif(rx_sif)
    );

    // Lock is sticky until reset; every line bit seeds until lock, and a long idle run is the only way to lock
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ones_ff <= 5'h0;
            rx_lock_ff <= 1'b0;
        end else if (tick && !rx_lock_ff) begin
            ones_ff <= plain ? ones_ff + 5'h1 : 5'h0;
            rx_lock_ff <= plain && (ones_ff == LOCK_ONES - 5'h1);
        end
    end

    assign grp = {win_ff[3:0], plain};
    assign dec = fx_dec(grp);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            win_ff <= 10'h0;
        end else if (tick) begin
            win_ff <= {win_ff[8:0], plain};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_st_ff <= RX_HUNT;
            rx_cnt_ff <= 3'h0;
            pre2_ff <= 1'b0;
            rxd_ff <= 4'h0;
            rx_dv_ff <= 1'b0;
            rx_nib_vld_ff <= 1'b0;
            rx_er_ff <= 1'b0;
        end else begin
            rx_nib_vld_ff <= 1'b0;
            rx_er_ff <= 1'b0;
            if (tick) begin
                rx_cnt_ff <= (rx_cnt_ff == BIT_LAST) ? 3'h0 : rx_cnt_ff + 3'h1;
                unique case (rx_st_ff)
                    RX_HUNT: begin
                        if (rx_lock_ff && {win_ff[8:0], plain} == {CG_J, CG_K}) begin
                            rx_st_ff <= RX_FRAME;
                            rx_cnt_ff <= 3'h0;
                            pre2_ff <= 1'b1;
                            rxd_ff <= NIB_PRE;
                            rx_dv_ff <= 1'b1;
                            rx_nib_vld_ff <= 1'b1;
                        end
                    end
                    RX_FRAME: begin
                        if (pre2_ff && rx_cnt_ff == BIT_PRE2) begin
                            pre2_ff <= 1'b0;
                            rxd_ff <= NIB_PRE;
                            rx_nib_vld_ff <= 1'b1;
                        end else if (rx_cnt_ff == BIT_LAST) begin
                            if (dec.ok) begin
                                rxd_ff <= dec.nib;
                                rx_nib_vld_ff <= 1'b1;
                            end else if (grp == CG_T) begin
                                rx_st_ff <= RX_END;
                                rx_dv_ff <= 1'b0;
                            end else if (grp == CG_I) begin
                                rx_st_ff <= RX_HUNT;
                                rx_dv_ff <= 1'b0;
                                rx_er_ff <= 1'b1;
                            end else begin
                                rx_er_ff <= 1'b1;
                            end
                        end
                    end
                    RX_END: begin
                        if (rx_cnt_ff == BIT_LAST) begin
                            rx_st_ff <= RX_HUNT;
                            rx_er_ff <= (grp != CG_R);
                        end
                    end
                endcase
            end
        end
    end
endmodule : fx_pcs

// ---- hdl/fx_pkg.sv ----
// Constants, code groups and state types of the 100 Mb/s coding path.
// Assumes a single core clock; the line clock is sampled, never used as a clock.
package fx_pkg;
    localparam int GRP_W = 5;
    localparam int NIB_W = 4;
    localparam int SCR_W = 11;
    localparam int SCR_TAP_A = 10;
    localparam int SCR_TAP_B = 8;
    localparam logic [SCR_W-1:0] SCR_RST = 11'h7ff;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0d;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_I = 5'h1f;
    localparam logic [3:0] NIB_PRE = 4'h5;
    localparam logic [2:0] BIT_LAST = 3'h4;
    localparam logic [2:0] BIT_PRE2 = 3'h2;
    localparam logic [4:0] LOCK_ONES = 5'h1e;
    localparam logic [1:0] MLT_POS = 2'h1;
    localparam logic [1:0] MLT_NEG = 2'h3;

    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_J    = 6'h02,
        TX_K    = 6'h04,
        TX_DATA = 6'h08,
        TX_T    = 6'h10,
        TX_R    = 6'h20
    } fx_tx_e;

    typedef enum logic [2:0] {
        RX_HUNT  = 3'h1,
        RX_FRAME = 3'h2,
        RX_END   = 3'h4
    } fx_rx_e;

    typedef struct packed {
        logic ok;
        logic [NIB_W-1:0] nib;
    } fx_dec_s;

    function automatic logic [GRP_W-1:0] fx_enc(input logic [NIB_W-1:0] nib);
        logic [GRP_W-1:0] cg;
        cg = CG_I;
        unique case (nib)
            4'h0: cg = 5'h1e;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0a;
            4'h5: cg = 5'h0b;
            4'h6: cg = 5'h0e;
            4'h7: cg = 5'h0f;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'ha: cg = 5'h16;
            4'hb: cg = 5'h17;
            4'hc: cg = 5'h1a;
            4'hd: cg = 5'h1b;
            4'he: cg = 5'h1c;
            4'hf: cg = 5'h1d;
        endcase
        return cg;
    endfunction : fx_enc

    function automatic fx_dec_s fx_dec(input logic [GRP_W-1:0] cg);
        fx_dec_s d;
        d.ok = 1'b0;
        d.nib = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (fx_enc(i[NIB_W-1:0]) == cg) begin
                d.ok = 1'b1;
                d.nib = i[NIB_W-1:0];
            end
        end
        return d;
    endfunction : fx_dec
endpackage : fx_pkg

// ---- hdl/fx_scr_if.sv ----
// Link between the coding path and its scrambler generators.
// Assumes both ends sit on the same core clock.
interface fx_scr_if #(parameter int W = 5);
    logic step;
    logic seed_en;
    logic [W-1:0] seed;
    logic [W-1:0] key;
    modport gen (input step, input seed_en, input seed, output key);
    modport user (output step, output seed_en, output seed, input key);
endinterface : fx_scr_if

// ---- hdl/fx_scr.sv ----
// Scrambler key generator, W key bits per step, first bit in the msb.
// Assumes the user steps it once per W line bits.
module fx_scr
    import fx_pkg::*;
#(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic resetn,
    fx_scr_if.gen sif
);
    logic [SCR_W-1:0] state_ff;
    logic [SCR_W-1:0] nxt_state;

    // Seeding loads the line's own sequence so the receiver self-aligns
    always_comb begin
        logic nb;
        nb = 1'b0;
        nxt_state = state_ff;
        sif.key = '0;
        for (int i = 0; i < W; i++) begin
            nb = nxt_state[SCR_TAP_A] ^ nxt_state[SCR_TAP_B];
            sif.key[W-1-i] = nb;
            nxt_state = {nxt_state[SCR_W-2:0], sif.seed_en ? sif.seed[W-1-i] : nb};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= SCR_RST;
        end else if (sif.step) begin
            state_ff <= nxt_state;
        end
    end
endmodule : fx_scr

// ---- dv/fx_pcs_props.sv ----
// Port checker for the 100 Mb/s coding path.
// Assumes a bind onto fx_pcs; line_clk is only sampled on clk.
module fx_pcs_props
    import fx_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic line_clk,
    input wire logic tx_take_ff,
    input wire logic tx_p_ff,
    input wire logic tx_n_ff,
    input wire logic [3:0] rxd_ff,
    input wire logic rx_dv_ff,
    input wire logic rx_nib_vld_ff,
    input wire logic rx_er_ff,
    input wire logic rx_lock_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic pos_ff;
    logic lc_ff;
    logic [5:0] age_ff;
    // Last nonzero level; plus comes first after reset
    always_ff @(posedge clk) begin
        if (!resetn) pos_ff <= 1'b0;
        else if (tx_p_ff) pos_ff <= 1'b1;
        else if (tx_n_ff) pos_ff <= 1'b0;
    end
    // Cycles since a line clock rise; saturates so slow links never wrap back into the legal window
    always_ff @(posedge clk) begin
        lc_ff <= line_clk;
        if (!resetn) age_ff <= 6'h3f;
        else if (line_clk && !lc_ff) age_ff <= 6'h00;
        else if (age_ff != 6'h3f) age_ff <= age_ff + 6'h01;
    end
    a_mlt_exclusive: assert property (!(tx_p_ff && tx_n_ff))
        else $error("both drive streams high");
    a_plus_after_minus: assert property ($rose(tx_p_ff) |-> !pos_ff)
        else $error("plus level repeated");
    a_minus_after_plus: assert property ($rose(tx_n_ff) |-> pos_ff)
        else $error("minus level repeated");
    a_mlt_via_zero: assert property ($fell(tx_p_ff) || $fell(tx_n_ff)
        |-> !tx_p_ff && !tx_n_ff)
        else $error("line skipped the zero level");
    a_line_on_tick: assert property (($changed(tx_p_ff) || $changed(tx_n_ff))
        |-> age_ff >= 6'h01 && age_ff <= 6'h0c)
        else $error("line changed away from a bit tick");
    a_take_spaced: assert property (tx_take_ff |=> !tx_take_ff [*8])
        else $error("nibble takes too close");
    a_nib_in_frame: assert property (rx_nib_vld_ff |-> rx_dv_ff)
        else $error("nibble outside a frame");
    a_frame_starts: assert property ($rose(rx_dv_ff)
        |-> rx_nib_vld_ff && rxd_ff == NIB_PRE && rx_lock_ff)
        else $error("frame did not open with preamble nibble");
    a_lock_sticky: assert property (rx_lock_ff |=> rx_lock_ff)
        else $error("descrambler lock lost");
    a_er_pulse: assert property (rx_er_ff |=> !rx_er_ff)
        else $error("error flag longer than one cycle");
    c_frame: cover property ($rose(rx_dv_ff));
    c_error: cover property (rx_er_ff);
    c_take: cover property (tx_take_ff);
endmodule : fx_pcs_props

// ---- dv/fx_loop.sv ----
// Far-end partner: a cable that sends our MLT-3 levels straight back.
// Assumes line_clk is the bit clock; levels change mid-bit.
module fx_loop (
    input wire logic line_clk,
    input wire logic tx_p,
    input wire logic tx_n,
    input wire logic corrupt,
    output logic rx_p,
    output logic rx_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic p_ff = 1'b0;
    logic n_ff = 1'b0;
    logic q_p = 1'b0;
    logic q_n = 1'b0;
    always @(posedge line_clk) begin
        p_ff <= tx_p;
        n_ff <= tx_n;
    end
    // Corruption freezes the level, so every bit reads as zero
    always @(negedge line_clk) begin
        if (!corrupt) begin
            q_p <= p_ff;
            q_n <= n_ff;
        end
    end
    assign rx_p = q_p;
    assign rx_n = q_n;
endmodule : fx_loop

// ---- dv/test_fx_pcs.sv ----
// Bench for the coding path: MAC frames looped back over the line.
// Assumes the loopback partner and the port checker beside the design.
module test_fx_pcs
    import fx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, line_clk = 1'b0, tx_en = 1'b0, corrupt = 1'b0;
    logic [3:0] txd = 4'h0;
    logic tx_take_ff, tx_p_ff, tx_n_ff, rx_p, rx_n, rx_dv_ff, rx_nib_vld_ff, rx_er_ff;
    logic rx_lock_ff;
    logic [3:0] rxd_ff;
    int mismatches = 0, total_checks = 0, er_cnt = 0, n;
    logic [3:0] got[$], exp_q[$], frm[$];
    // Rows: nibble sent, nibble expected back, code group expected on the line
    logic [15:0] rows[16] = '{16'h001e, 16'h1109, 16'h2214, 16'h3315, 16'h440a, 16'h550b,
        16'h660e, 16'h770f, 16'h8812, 16'h9913, 16'haa16, 16'hbb17, 16'hcc1a, 16'hdd1b,
        16'hee1c, 16'hff1d};
    fx_pcs dut (.clk, .resetn, .line_clk, .tx_en, .txd, .tx_take_ff, .tx_p_ff, .tx_n_ff,
        .rx_p, .rx_n, .rxd_ff, .rx_dv_ff, .rx_nib_vld_ff, .rx_er_ff, .rx_lock_ff);
    fx_loop u_far (.line_clk, .tx_p(tx_p_ff), .tx_n(tx_n_ff), .corrupt, .rx_p, .rx_n);
    initial begin
        forever #2 clk = ~clk;
    end
    // Odd start keeps the line clock off the core clock edges
    initial begin
        #37;
        forever #80 line_clk = ~line_clk;
    end
    // Line monitor with its own descrambler, so the code table is not judged by itself
    logic [1:0] mon_lvl = 2'h0;
    logic [10:0] mon_lfsr = 11'h0;
    logic [9:0] mon_win = 10'h0;
    logic mon_lock = 1'b0, mon_in = 1'b0;
    int mon_ones = 0, mon_cnt = 0;
    logic [4:0] cg_q[$];
    always @(posedge line_clk) begin : line_mon
        logic b, k, d;
        b = ({tx_p_ff, tx_n_ff} != mon_lvl);
        k = mon_lfsr[10] ^ mon_lfsr[8];
        d = b ^ k;
        mon_lvl = {tx_p_ff, tx_n_ff};
        // Idle is all ones, so until lock the line bit gives the key away
        mon_lfsr = {mon_lfsr[9:0], mon_lock ? k : ~b};
        mon_ones = d ? mon_ones + 1 : 0;
        if (mon_ones >= 30) mon_lock = 1'b1;
        mon_win = {mon_win[8:0], d};
        mon_cnt++;
        if (mon_lock && !mon_in && mon_win == {CG_J, CG_K}) begin
            mon_in = 1'b1;
            mon_cnt = 0;
        end else if (mon_in && mon_cnt == 5) begin
            mon_cnt = 0;
            if (mon_win[4:0] == CG_T) mon_in = 1'b0;
            else cg_q.push_back(mon_win[4:0]);
        end
    end
    always @(posedge clk) begin
        if (rx_nib_vld_ff === 1'b1) got.push_back(rxd_ff);
        if (rx_er_ff === 1'b1) er_cnt++;
    end
    task automatic chk_val(input string name, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask : chk_val
    task automatic chk_num(input string name, input int e, input int g);
        total_checks++;
        if (g != e) begin
            mismatches++;
            $display("FAIL %s expected %0d seen %0d", name, e, g);
        end
    endtask : chk_num
    task automatic chk_grp(input string name, input logic [4:0] e, input logic [4:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask : chk_grp
    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic wait_take;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_take_ff !== 1'b1 && n < 400);
        chk_num("take wait", 1, n < 400);
    endtask : wait_take
    // Six rises let the end slot sample tx_en low before any next frame
    task automatic send;
        foreach (frm[i]) begin
            tx_en <= 1'b1;
            txd <= frm[i];
            wait_take();
        end
        tx_en <= 1'b0;
        repeat (6) @(posedge line_clk);
        @(posedge clk);
    endtask : send
    task automatic wait_dv;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rx_dv_ff !== 1'b0 && n < 2000);
        chk_val("frame end", 4'h0, {3'h0, rx_dv_ff});
    endtask : wait_dv
    initial begin
        repeat (16) @(posedge clk);
        chk_val("quiet", 4'h0, {tx_p_ff | tx_n_ff, rx_dv_ff | rx_lock_ff,
            tx_take_ff | rx_nib_vld_ff, rx_er_ff});
        resetn <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rx_lock_ff !== 1'b1 && n < 5000);
        chk_val("lock", 4'h1, {3'h0, rx_lock_ff});
        frm = {NIB_PRE, NIB_PRE};
        exp_q = {NIB_PRE, NIB_PRE};
        foreach (rows[i]) begin
            frm.push_back(rows[i][15:12]);
            exp_q.push_back(rows[i][11:8]);
        end
        send();
        // Back-to-back frame: R is followed straight by J
        frm = {NIB_PRE, NIB_PRE, 4'h3, 4'hc};
        exp_q = {exp_q, frm};
        send();
        wait_dv();
        chk_num("nibbles", exp_q.size(), got.size());
        foreach (exp_q[i]) chk_val("rx nibble", exp_q[i], got[i]);
        chk_num("errors", 0, er_cnt);
        chk_num("tx groups", 18, cg_q.size());
        foreach (rows[i]) chk_grp("tx group", rows[i][4:0], cg_q[i]);
        chk_grp("tx group", 5'h15, cg_q[16]);
        chk_grp("tx group", 5'h1a, cg_q[17]);
        er_cnt = 0;
        frm = {NIB_PRE, NIB_PRE};
        repeat (10) frm.push_back(4'ha);
        fork
            send();
            begin
                repeat (25) @(posedge line_clk);
                @(posedge clk) corrupt <= 1'b1;
                repeat (20) @(posedge line_clk);
                @(posedge clk) corrupt <= 1'b0;
            end
        join
        wait_dv();
        chk_num("bad frame flagged", 1, er_cnt > 0);
        tx_en <= 1'b1;
        txd <= NIB_PRE;
        wait_take();
        wait_take();
        resetn <= 1'b0;
        tx_en <= 1'b0;
        repeat (4) @(posedge clk);
        chk_val("quiet again", 4'h0, {tx_p_ff | tx_n_ff, rx_dv_ff | rx_lock_ff,
            tx_take_ff | rx_nib_vld_ff, rx_er_ff});
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk_val("quiet after release", 4'h0, {tx_p_ff | tx_n_ff, rx_dv_ff | rx_lock_ff,
            tx_take_ff | rx_nib_vld_ff, rx_er_ff});
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule : test_fx_pcs
bind fx_pcs fx_pcs_props u_props (.clk, .resetn, .line_clk, .tx_take_ff, .tx_p_ff, .tx_n_ff,
    .rxd_ff, .rx_dv_ff, .rx_nib_vld_ff, .rx_er_ff, .rx_lock_ff);
